//--- rtl/pwmsc_channel.sv
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pwmsc_channel #(
  parameter logic [1:0] OWN_CODE = 2'b01
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_tick,
  input wire logic [3:1] sibling_sync_pulse,
  input wire logic [3:1] sibling_load_pulse,
  output logic sync_pulse_out,
  output logic load_pulse_out,
  output logic pwm_pin,
  output logic pwm_pin_oe,
  output logic irq
);
  logic rst_s1_r, rst_n;
  logic [7:0] ctrl_r, ie_r, ir_r, clk_r, ld_r, sync_r;
  pwmsc_pkg::pwmsc_cmp_t buf_r, act_r;
  logic [15:0] cnt_r;
  logic dir_down_r, running_r, out_r;
  logic sync_prev_r, load_prev_r, trig_seen_r;
  logic wr, rd, src_tick, tick, boundary, sync_rise, load_rise, do_load;
  logic sync_sel, load_sel, sw_out_wr;
  logic [1:0] mode, smode;
  pwmsc_pkg::pwmsc_match_t match;
  logic [3:0] match_rise;
  logic [31:0] prdata_nxt, prdata_r;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // apb strobes, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite; // read captured in setup
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign mode = ctrl_r[pwmsc_pkg::CTRL_MODE_LO +: 2];
  assign smode = sync_r[pwmsc_pkg::SYNC_MODE_LO +: 2];
  assign sw_out_wr = wr && (paddr == pwmsc_pkg::ADDR_CTRL);

  // clock source select and sleep gating
  always_comb begin
    unique case (clk_r[1:0])
      pwmsc_pkg::CS_SYS: src_tick = !sleep;
      2'b01: src_tick = fast_osc_tick;
      2'b10: src_tick = slow_osc_tick;
      default: src_tick = 1'b0;
    endcase
  end

  pwmsc_prescale u_ps (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src_tick(src_tick && ctrl_r[pwmsc_pkg::CTRL_EN]),
    .ps(clk_r[pwmsc_pkg::CLK_PS_LO +: 3]),
    .tick(tick)
  );

  // sibling selection; reserved codes select nothing
  always_comb begin
    sync_sel = 1'b0;
    load_sel = 1'b0;
    if (sync_r[1:0] != pwmsc_pkg::SRC_RSVD && sync_r[1:0] != OWN_CODE) begin
      sync_sel = sibling_sync_pulse[sync_r[1:0]];
    end
    if (ld_r[1:0] != pwmsc_pkg::SRC_RSVD && ld_r[1:0] != OWN_CODE) begin
      load_sel = sibling_load_pulse[ld_r[1:0]];
    end
  end
  assign sync_rise = sync_sel && !sync_prev_r;
  assign load_rise = load_sel && !load_prev_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      load_prev_r <= 1'b0;
    end else begin
      sync_prev_r <= sync_sel;
      load_prev_r <= load_sel;
    end
  end

  // period boundary: counter reaches period (centre: returns to zero)
  always_comb begin
    if (mode == pwmsc_pkg::MODE_CENTRE) begin
      boundary = tick && running_r && dir_down_r && (cnt_r == pwmsc_pkg::RST16);
    end else begin
      boundary = tick && running_r && (cnt_r == act_r.pr);
    end
  end

  // reload: armed, trigger satisfied, at boundary
  assign do_load = boundary && ld_r[pwmsc_pkg::LD_ARM]
    && (!ld_r[pwmsc_pkg::LD_TRIG] || trig_seen_r || load_rise)
    && !(wr && paddr == pwmsc_pkg::ADDR_LD && cnt_r == act_r.pr);

  // trigger seen latch for triggered reload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_seen_r <= 1'b0;
    end else if (do_load || !ld_r[pwmsc_pkg::LD_ARM]) begin
      trig_seen_r <= 1'b0;
    end else if (load_rise) begin
      trig_seen_r <= 1'b1;
    end
  end

  // buffered values written by software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= '0;
    end else if (wr) begin
      unique case (paddr)
        pwmsc_pkg::ADDR_PH: buf_r.ph <= pwdata[15:0];
        pwmsc_pkg::ADDR_DC: buf_r.dc <= pwdata[15:0];
        pwmsc_pkg::ADDR_PR: buf_r.pr <= pwdata[15:0];
        pwmsc_pkg::ADDR_OF: buf_r.of <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // active compares change only on reload
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= '0;
    end else if (do_load) begin
      act_r <= buf_r;
    end
  end

  // counter with slave sync modes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= pwmsc_pkg::RST16;
      dir_down_r <= 1'b0;
      running_r <= 1'b0;
    end else if (!ctrl_r[pwmsc_pkg::CTRL_EN]) begin
      cnt_r <= pwmsc_pkg::RST16;
      dir_down_r <= 1'b0;
      running_r <= 1'b0;
    end else if (smode == pwmsc_pkg::SYNC_CONT && running_r && sync_rise) begin
      cnt_r <= pwmsc_pkg::ONE16;
      dir_down_r <= 1'b0;
    end else if (!running_r) begin
      // restart from zero; a one-shot run may be parked at period
      if (smode == 2'b00 || sync_rise) begin
        running_r <= 1'b1;
        cnt_r <= pwmsc_pkg::RST16;
      end
    end else if (tick) begin
      if (mode == pwmsc_pkg::MODE_CENTRE) begin
        if (!dir_down_r) begin
          if (cnt_r == act_r.pr) begin
            dir_down_r <= 1'b1;
            cnt_r <= 16'(cnt_r - pwmsc_pkg::ONE16);
          end else begin
            cnt_r <= 16'(cnt_r + pwmsc_pkg::ONE16);
          end
        end else if (cnt_r == pwmsc_pkg::RST16) begin
          dir_down_r <= 1'b0;
          cnt_r <= pwmsc_pkg::ONE16;
          running_r <= (smode != pwmsc_pkg::SYNC_ONESHOT);
        end else begin
          cnt_r <= 16'(cnt_r - pwmsc_pkg::ONE16);
        end
      end else if (cnt_r == act_r.pr && smode == pwmsc_pkg::SYNC_ONESHOT) begin
        running_r <= 1'b0;
      end else if (cnt_r == act_r.pr) begin
        cnt_r <= pwmsc_pkg::RST16;
      end else begin
        cnt_r <= 16'(cnt_r + pwmsc_pkg::ONE16);
      end
    end
  end

  // match levels while running
  always_comb begin
    match.ph = running_r && (cnt_r == act_r.ph);
    match.dc = running_r && (cnt_r == act_r.dc);
    match.pr = running_r && (cnt_r == act_r.pr);
    match.of = running_r && (cnt_r == act_r.of);
    if (mode == pwmsc_pkg::MODE_CENTRE) begin
      match.of = match.of && (dir_down_r == sync_r[pwmsc_pkg::SYNC_DOWN]);
    end
  end
  assign sync_pulse_out = match.of;
  assign load_pulse_out = do_load;

  pwmsc_edge u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lvl(match),
    .rise(match_rise)
  );

  // waveform output per mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (!ctrl_r[pwmsc_pkg::CTRL_EN]) begin
      out_r <= sw_out_wr ? pwdata[pwmsc_pkg::CTRL_OUT] : 1'b0;
    end else begin
      unique case (mode)
        2'b00: begin
          if (match.dc) out_r <= 1'b0;
          else if (match.ph) out_r <= 1'b1;
        end
        2'b01: begin
          if (match.ph) out_r <= 1'b1;
          else if (sw_out_wr) out_r <= pwdata[pwmsc_pkg::CTRL_OUT];
        end
        2'b10: begin
          if (match_rise[pwmsc_pkg::IRQ_PH]) out_r <= !out_r;
        end
        2'b11: begin
          if (running_r) out_r <= dir_down_r ? (cnt_r > act_r.dc) : (cnt_r >= act_r.dc);
        end
      endcase
    end
  end
  assign pwm_pin = out_r ^ ctrl_r[pwmsc_pkg::CTRL_POL];
  assign pwm_pin_oe = ctrl_r[pwmsc_pkg::CTRL_EN] && ctrl_r[pwmsc_pkg::CTRL_OE];

  // control, enable, clock and sync registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= pwmsc_pkg::RST8;
      ie_r <= pwmsc_pkg::RST8;
      clk_r <= pwmsc_pkg::RST8;
      sync_r <= pwmsc_pkg::RST8;
    end else if (wr) begin
      unique case (paddr)
        pwmsc_pkg::ADDR_CTRL: ctrl_r <= pwdata[7:0] & pwmsc_pkg::CTRL_MASK;
        pwmsc_pkg::ADDR_IE: ie_r <= pwdata[7:0] & pwmsc_pkg::IE_MASK;
        pwmsc_pkg::ADDR_CLK: clk_r <= pwdata[7:0] & pwmsc_pkg::CLK_MASK;
        pwmsc_pkg::ADDR_SYNC: sync_r <= pwdata[7:0] & pwmsc_pkg::SYNC_MASK;
        default: ;
      endcase
    end
  end

  // reload control; hardware clears the arm bit after load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_r <= pwmsc_pkg::RST8;
    end else if (wr && paddr == pwmsc_pkg::ADDR_LD) begin
      ld_r <= pwdata[7:0] & pwmsc_pkg::LD_MASK;
    end else if (do_load) begin
      ld_r[pwmsc_pkg::LD_ARM] <= 1'b0;
    end
  end

  // flags: set wins over write-one-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_r <= pwmsc_pkg::RST8;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (match_rise[i]) begin
          ir_r[i] <= 1'b1;
        end else if (wr && paddr == pwmsc_pkg::ADDR_IR && pwdata[i]) begin
          ir_r[i] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(ir_r[3:0] & ie_r[3:0]);

  // read mux; out bit shows live state
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        pwmsc_pkg::ADDR_CTRL: prdata_nxt[7:0] = {ctrl_r[7:6], out_r, ctrl_r[4:0]};
        pwmsc_pkg::ADDR_IE: prdata_nxt[7:0] = ie_r;
        pwmsc_pkg::ADDR_IR: prdata_nxt[7:0] = ir_r;
        pwmsc_pkg::ADDR_CLK: prdata_nxt[7:0] = clk_r;
        pwmsc_pkg::ADDR_LD: prdata_nxt[7:0] = ld_r;
        pwmsc_pkg::ADDR_SYNC: prdata_nxt[7:0] = sync_r;
        pwmsc_pkg::ADDR_PH: prdata_nxt[15:0] = buf_r.ph;
        pwmsc_pkg::ADDR_DC: prdata_nxt[15:0] = buf_r.dc;
        pwmsc_pkg::ADDR_PR: prdata_nxt[15:0] = buf_r.pr;
        pwmsc_pkg::ADDR_OF: prdata_nxt[15:0] = buf_r.of;
        pwmsc_pkg::ADDR_CNT: prdata_nxt[15:0] = cnt_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data flop: loaded in setup, stands through access, zero when idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd) begin
      prdata_r <= prdata_nxt;
    end else if (!psel) begin
      prdata_r <= 32'h0000_0000;
    end
  end
  assign prdata = prdata_r;
endmodule : pwmsc_channel

//--- shared/pwmsc_pkg.sv
package pwmsc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IE = 8'h04;
  localparam logic [7:0] ADDR_IR = 8'h08;
  localparam logic [7:0] ADDR_CLK = 8'h0c;
  localparam logic [7:0] ADDR_LD = 8'h10;
  localparam logic [7:0] ADDR_SYNC = 8'h14;
  localparam logic [7:0] ADDR_PH = 8'h18;
  localparam logic [7:0] ADDR_DC = 8'h1c;
  localparam logic [7:0] ADDR_PR = 8'h20;
  localparam logic [7:0] ADDR_OF = 8'h24;
  localparam logic [7:0] ADDR_CNT = 8'h28;
  // field positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_OE = 6;
  localparam int CTRL_OUT = 5;
  localparam int CTRL_POL = 4;
  localparam int CTRL_MODE_LO = 2;
  localparam int LD_ARM = 7;
  localparam int LD_TRIG = 6;
  localparam int CLK_PS_LO = 4;
  localparam int SYNC_MODE_LO = 5;
  localparam int SYNC_DOWN = 4;
  localparam int IRQ_OF = 3;
  localparam int IRQ_PH = 2;
  localparam int IRQ_DC = 1;
  localparam int IRQ_PR = 0;
  // writable masks
  localparam logic [7:0] CTRL_MASK = 8'hfc;
  localparam logic [7:0] IE_MASK = 8'h0f;
  localparam logic [7:0] CLK_MASK = 8'h73;
  localparam logic [7:0] LD_MASK = 8'hc3;
  localparam logic [7:0] SYNC_MASK = 8'h73;
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [15:0] ONE16 = 16'h0001;
  // encodings
  localparam logic [1:0] MODE_CENTRE = 2'b11;
  localparam logic [1:0] SYNC_ONESHOT = 2'b10;
  localparam logic [1:0] SYNC_CONT = 2'b11;
  localparam logic [1:0] SYNC_START = 2'b01;
  localparam logic [1:0] CS_SYS = 2'b00;
  localparam logic [1:0] CS_RSVD = 2'b11;
  localparam logic [1:0] SRC_RSVD = 2'b00;
  typedef struct packed {
    logic [15:0] ph;
    logic [15:0] dc;
    logic [15:0] pr;
    logic [15:0] of;
  } pwmsc_cmp_t;
  typedef struct packed {
    logic of;
    logic ph;
    logic dc;
    logic pr;
  } pwmsc_match_t;
endpackage : pwmsc_pkg

//--- rtl/pwmsc_prescale.sv
`timescale 1ns/1ps
module pwmsc_prescale (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [2:0] ps,
  output logic tick
);
  logic [6:0] cnt_r;
  logic [6:0] lim;
  // divisor is two to the code
  assign lim = 7'((8'h01 << ps) - 8'h01);
  assign tick = src_tick && (cnt_r == lim);
  // count source ticks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
    end else if (src_tick) begin
      cnt_r <= (cnt_r >= lim) ? 7'h00 : 7'(cnt_r + 7'h01);
    end
  end
endmodule : pwmsc_prescale

//--- rtl/pwmsc_edge.sv
`timescale 1ns/1ps
module pwmsc_edge (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] lvl,
  output logic [3:0] rise
);
  // one-cycle pulse per rising level; each bit keeps its own history flop
  for (genvar i = 0; i < 4; i++) begin : g_e
    logic prev_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        prev_r <= 1'b0;
      end else begin
        prev_r <= lvl[i];
      end
    end
    assign rise[i] = lvl[i] && !prev_r;
  end
endmodule : pwmsc_edge

//--- sim/pwmsc_checker.sv
`timescale 1ns/1ps
module pwmsc_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic load_pulse_out,
  input wire logic pwm_pin,
  input wire logic pwm_pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // bus phase decode
  logic rd;
  logic wr;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  // pin against control state; read data was taken one cycle back, in setup
  chk_pin_polarity: assert property (rd && paddr == pwmsc_pkg::ADDR_CTRL
    |-> $past(pwm_pin) == (prdata[5] ^ prdata[4])) else $error("pin not state xor invert");
  chk_pin_enable: assert property (rd && paddr == pwmsc_pkg::ADDR_CTRL
    |-> $past(pwm_pin_oe) == (prdata[7] && prdata[6])) else $error("pin enable wrong");
  chk_oe_write: assert property (wr && paddr == pwmsc_pkg::ADDR_CTRL
    && pwdata[7:6] == 2'h3 |=> pwm_pin_oe) else $error("pin enable not set");
  // reserved bits
  chk_ld_reserved: assert property (rd && paddr == pwmsc_pkg::ADDR_LD
    |-> prdata[5:2] == 4'h0 && prdata[31:8] == 24'h00_0000) else $error("reload bits");
  chk_clk_reserved: assert property (rd && paddr == pwmsc_pkg::ADDR_CLK
    |-> prdata[7] == 1'h0 && prdata[3:2] == 2'h0) else $error("clock bits");
  chk_flag_layout: assert property (rd && paddr == pwmsc_pkg::ADDR_IR
    |-> prdata[31:4] == 28'h000_0000) else $error("flag upper bits");
  // interrupt gating
  chk_irq_idle: assert property (rd && paddr == pwmsc_pkg::ADDR_IR
    && prdata[3:0] == 4'h0 |-> !$past(irq)) else $error("irq without flag");
  chk_irq_masked: assert property (wr && paddr == pwmsc_pkg::ADDR_IE
    && pwdata[3:0] == 4'h0 |=> !irq [*2]) else $error("irq while masked");
  chk_load_single: assert property (load_pulse_out |=> !load_pulse_out)
    else $error("reload pulse repeated");
  // scenarios reached
  cover property (wr && paddr == pwmsc_pkg::ADDR_LD && pwdata[7]);
  cover property (load_pulse_out);
  cover property ($rose(irq));
endmodule : pwmsc_checker

bind pwmsc_channel pwmsc_checker u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .load_pulse_out(load_pulse_out),
  .pwm_pin(pwm_pin), .pwm_pin_oe(pwm_pin_oe), .irq(irq));

//--- sim/pwmsc_sibling_model.sv
`timescale 1ns/1ps
module pwmsc_sibling_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:1] fire_sync,
  input wire logic [3:1] fire_load,
  output logic [3:1] sync_lvl,
  output logic [3:1] load_lvl,
  output logic fast_tick,
  output logic slow_tick
);
  logic [3:0] div_r;
  // oscillator divider
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  assign fast_tick = div_r[0];
  assign slow_tick = &div_r;
  // sibling matches, held long enough for a slower slave
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_lvl <= 3'h0;
      load_lvl <= 3'h0;
    end else begin
      sync_lvl <= fire_sync;
      load_lvl <= fire_load;
    end
  end
endmodule : pwmsc_sibling_model

//--- sim/test_pwm_slave_sync_reload_irq.sv
`timescale 1ns/1ps
module test_pwm_slave_sync_reload_irq;
  localparam logic [31:0] zero_w = 32'h0000_0000;
  logic core_clk, rstn, psel, penable, pwrite, sleep, pready, pslverr;
  logic sync_out, load_out, pin, pin_oe, irq, fast, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, mx;
  logic [3:1] sync_in, load_in, fire_sync, fire_load;
  int num_errors, n_compared, cycles;
  // channel and its neighbours
  pwmsc_channel DUT (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep(sleep), .fast_osc_tick(fast), .slow_osc_tick(slow), .sibling_sync_pulse(sync_in),
    .sibling_load_pulse(load_in), .sync_pulse_out(sync_out), .load_pulse_out(load_out),
    .pwm_pin(pin), .pwm_pin_oe(pin_oe), .irq(irq));
  pwmsc_sibling_model u_sib (
    .core_clk(core_clk), .rstn(rstn), .fire_sync(fire_sync), .fire_load(fire_load),
    .sync_lvl(sync_in), .load_lvl(load_in), .fast_tick(fast), .slow_tick(slow));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, read data kept in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, zero_w);
    check(rd, e);
  endtask : rd_chk
  task automatic peak;
    mx = zero_w;
    repeat (20) begin
      bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
      if (rd > mx) mx = rd;
    end
  endtask : peak
  task automatic poll_ld;
    repeat (30) begin
      bus(1'b0, pwmsc_pkg::ADDR_LD, zero_w);
      if (rd[7] === 1'b0) break;
    end
  endtask : poll_ld
  task automatic fire(input logic ld, input logic [3:1] m);
    @(posedge core_clk);
    if (ld) fire_load <= m;
    else fire_sync <= m;
    repeat (4) @(posedge core_clk);
    fire_load <= 3'h0;
    fire_sync <= 3'h0;
  endtask : fire
  task automatic t_regs;
    for (int a = 0; a <= 44; a += 4) begin
      rd_chk(8'(a), zero_w);
    end
    bus(1'b1, pwmsc_pkg::ADDR_CLK, 8'hff);
    rd_chk(pwmsc_pkg::ADDR_CLK, 8'h73);
    bus(1'b1, pwmsc_pkg::ADDR_IE, 8'hff);
    rd_chk(pwmsc_pkg::ADDR_IE, 8'h0f);
    bus(1'b1, pwmsc_pkg::ADDR_LD, 8'h7f);
    rd_chk(pwmsc_pkg::ADDR_LD, 8'h43);
    bus(1'b1, 8'h2c, 8'hff);
    check({pready, pslverr}, 32'h0000_0002);
    rd_chk(8'h2c, zero_w);
    bus(1'b1, pwmsc_pkg::ADDR_CLK, zero_w);
    bus(1'b1, pwmsc_pkg::ADDR_IE, zero_w);
    bus(1'b1, pwmsc_pkg::ADDR_LD, zero_w);
  endtask : t_regs
  task automatic t_reload;
    bus(1'b1, pwmsc_pkg::ADDR_PR, 16'h0009);
    bus(1'b1, pwmsc_pkg::ADDR_LD, 8'h80);
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h80);
    poll_ld();
    check(rd, zero_w);
    bus(1'b1, pwmsc_pkg::ADDR_PR, 16'h00ff);
    peak();
    check(mx, 16'h0009);
    bus(1'b1, pwmsc_pkg::ADDR_LD, 8'hc2);
    peak();
    check(mx, 16'h0009);
    rd_chk(pwmsc_pkg::ADDR_LD, 8'hc2);
    fire(1'b1, 3'b010);
    poll_ld();
    check(rd, 8'h42);
    peak();
    check(mx > 16'h0009, 1'h1);
  endtask : t_reload
  task automatic t_slave;
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h00);
    bus(1'b1, pwmsc_pkg::ADDR_SYNC, 8'h43);
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h80);
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    mx = rd;
    fire(1'b0, 3'b011);
    repeat (20) @(posedge core_clk);
    rd_chk(pwmsc_pkg::ADDR_CNT, mx);
    fire(1'b0, 3'b100);
    repeat (300) @(posedge core_clk);
    rd_chk(pwmsc_pkg::ADDR_CNT, 16'h00ff);
    repeat (20) @(posedge core_clk);
    rd_chk(pwmsc_pkg::ADDR_CNT, 16'h00ff);
    bus(1'b1, pwmsc_pkg::ADDR_SYNC, 8'h63);
    fire(1'b0, 3'b100);
    repeat (100) @(posedge core_clk);
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    check(rd > 16'h0010, 1'h1);
    fire(1'b0, 3'b100);
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    check(rd < 16'h0010, 1'h1);
  endtask : t_slave
  task automatic t_irq_pin;
    bus(1'b1, pwmsc_pkg::ADDR_IR, 8'h0f);
    bus(1'b1, pwmsc_pkg::ADDR_IE, 8'h01);
    repeat (300) @(posedge core_clk);
    bus(1'b0, pwmsc_pkg::ADDR_IR, zero_w);
    check(rd[3:0], 4'hf);
    check(irq, 1'h1);
    bus(1'b1, pwmsc_pkg::ADDR_IE, 8'h00);
    @(posedge core_clk);
    check(irq, 1'h0);
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'hd0);
    bus(1'b0, pwmsc_pkg::ADDR_CTRL, zero_w);
    check(pin, rd[5] ^ 1'h1);
    check(pin_oe, 1'h1);
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h50);
    @(posedge core_clk);
    check(pin_oe, 1'h0);
  endtask : t_irq_pin
  task automatic t_sleep;
    bus(1'b1, pwmsc_pkg::ADDR_SYNC, 8'h00);
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h80);
    sleep <= 1'b1;
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    mx = rd;
    repeat (10) @(posedge core_clk);
    rd_chk(pwmsc_pkg::ADDR_CNT, mx);
    bus(1'b1, pwmsc_pkg::ADDR_CLK, 8'h01);
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    mx = rd;
    repeat (10) @(posedge core_clk);
    bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
    check(rd != mx, 1'h1);
    sleep <= 1'b0;
  endtask : t_sleep
  // centre mode: offset pulse on up or down pass, period 9, offset 2
  task automatic t_centre;
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, pwmsc_pkg::ADDR_CTRL, zero_w);
      bus(1'b1, pwmsc_pkg::ADDR_CLK, zero_w);
      bus(1'b1, pwmsc_pkg::ADDR_SYNC, 32'(s) << pwmsc_pkg::SYNC_DOWN);
      bus(1'b1, pwmsc_pkg::ADDR_PR, 16'h0009);
      bus(1'b1, pwmsc_pkg::ADDR_OF, 16'h0002);
      bus(1'b1, pwmsc_pkg::ADDR_LD, 8'h80);
      bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h8c);
      while (load_out !== 1'b1) @(posedge core_clk);
      @(posedge core_clk);
      while (sync_out !== 1'b1) @(posedge core_clk);
      // counter two ticks after the pulse: 4 going up, 0 going down
      bus(1'b0, pwmsc_pkg::ADDR_CNT, zero_w);
      check(rd, s ? 32'h0000_0000 : 32'h0000_0004);
    end
  endtask : t_centre
  // toggle mode: one pin change per phase match, ten per hundred cycles
  task automatic t_toggle;
    int n;
    logic p;
    n = 0;
    bus(1'b1, pwmsc_pkg::ADDR_CTRL, 8'h88);
    @(posedge core_clk);
    p = pin;
    repeat (100) begin
      @(posedge core_clk);
      if (pin !== p) n++;
      p = pin;
    end
    check(n, 32'h0000_000a);
  endtask : t_toggle
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, sleep} = 5'h00;
    paddr = 8'h00;
    pwdata = zero_w;
    fire_sync = 3'h0;
    fire_load = 3'h0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_reload();
    t_slave();
    t_irq_pin();
    t_sleep();
    t_centre();
    t_toggle();
    tally_and_finish();
  end
endmodule : test_pwm_slave_sync_reload_irq
